// [design/iratp_map.svh]
// register indices, field positions, reset values and timing counts
// assumes: byte address of a register is four times its index
`ifndef IRATP_MAP_SVH
`define IRATP_MAP_SVH
`define IRATP_IDX_OFFSET 8'h1A
`define IRATP_IDX_LED 8'h1C
`define IRATP_IDX_REC 8'h1D
`define IRATP_IDX_GAIN 8'h1E
`define IRATP_IDX_CTRL 8'h20
`define IRATP_IDX_STAT 8'h21
`define IRATP_IDX_RESULT 8'h22
`define IRATP_RST_OFFSET 8'h60
`define IRATP_RST_LED 8'h00
`define IRATP_RST_REC 8'h70
`define IRATP_RST_GAIN 8'h00
`define IRATP_REC_LSB 4
`define IRATP_REC_MSB 6
`define IRATP_GAIN_MSB 2
`define IRATP_CTRL_START 0
`define IRATP_STAT_BUSY 0
`define IRATP_STAT_DONE 1
`define IRATP_STAT_OVR 2
`define IRATP_OVERRANGE 16'hFFFF
`define IRATP_RESULT_MAX 16'hFFFE
`define IRATP_ADC_CLK_NS 32'h00000032
`define IRATP_SYS_CLK_NS 32'h00000064
`define IRATP_INTEG_TICKS 8'h04
`define IRATP_RESP_OKAY 2'h0
`define IRATP_RESP_SLVERR 2'h2
`endif

// [design/iratp_pkg.sv]
// types and shared arithmetic of the converter parameter block
// assumes: iratp_map.svh on the include path
`include "iratp_map.svh"
package iratp_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_recover = 2'b01,
        st_integ = 2'b10,
        st_report = 2'b11
    } iratp_state_e;
    typedef struct packed {
        logic [7:0] offset;
        logic [2:0] rec;
        logic [2:0] gain;
    } iratp_set_s;
    typedef struct packed {
        logic [15:0] value;
        logic overrange;
    } iratp_res_s;
    // compressed offset: upper nibble exponent, lower nibble mantissa
    function automatic logic [15:0] expand_offset(input logic [7:0] c);
        logic [31:0] w;
        w = ({27'h0, 1'b1, c[3:0]} << c[7:4]) >> 4;
        if (c == 8'h00) return 16'h0000;
        if (|w[31:16]) return 16'hFFFF;
        return w[15:0];
    endfunction
    // recovery in system cycles, rounded up
    function automatic logic [15:0] rec_cycles(input logic [2:0] r,
                                               input logic [2:0] g);
        logic [31:0] n;
        n = (r == 3'h0) ? 32'h1 :
            (32'h1 << ({29'h0, r} + 32'h2)) - 32'h1;
        n = (n << g) * `IRATP_ADC_CLK_NS;
        n = (n + `IRATP_SYS_CLK_NS - 32'h1) / `IRATP_SYS_CLK_NS;
        return n[15:0];
    endfunction
    function automatic logic [7:0] div_top(input logic [2:0] g);
        return (8'h01 << g) - 8'h01;
    endfunction
    function automatic logic [15:0] report_value(input logic [16:0] s,
                                                 input logic [15:0] o);
        logic signed [18:0] t;
        t = $signed({{2{s[16]}}, s}) + $signed({3'h0, o});
        if (t < 0) return 16'h0000;
        if (t > $signed({3'h0, `IRATP_RESULT_MAX})) return `IRATP_RESULT_MAX;
        return t[15:0];
    endfunction
endpackage

// [design/iratp_top.sv]
// converter offset, infrared recovery and gain parameters with sequencer
// assumes: AXI4-Lite master, synchronous front end giving signed samples
// Functional notes
// - the 8-bit offset code expands to 16 bits and is added to results
// - code FFFF only ever means overrange; results clamp at FFFE to stay off it
// - offset codes 60, 70, 80 expand to 64, 128 and 256 codes
// - each infrared measurement starts with a recovery wait from bits 6:4
// - recovery is 1,7,15..511 converter clocks of 50 ns, times 2^gain
// - integration lasts a base time times 2^gain, gain in bits 2:0
// - gain 7 gives the largest integration factor, 128
// - gain divides the converter clock: 0 by 1, 4 by 16, 6 by 64
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "iratp_map.svh"
module iratp_top (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // converter front end
    input wire logic start_in,
    input wire logic [16:0] sample_in,
    input wire logic overrange_in,
    // sequencer status
    output logic busy_out,
    output logic recovering_out,
    output logic integrating_out,
    output logic adc_tick_out,
    output logic result_valid_out,
    output iratp_pkg::iratp_res_s result_out
);
    import iratp_pkg::*;

    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_do;
    logic [7:0] wr_idx;
    logic wr_ok;
    logic [7:0] rd_idx;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [7:0] measurement_offset;
    logic [7:0] led_recovery_field;
    logic [2:0] infrared_recovery_code;
    logic [2:0] infrared_integration_gain;
    logic sw_start;
    logic done_flag;
    logic done_clear;
    iratp_state_e state;
    iratp_state_e next_state;
    iratp_set_s snap;
    logic start_go;
    logic [15:0] rec_left;
    logic [7:0] div_cnt;
    logic [7:0] integ_left;
    logic tick_now;
    logic ovr_seen;
    logic ovr_any;
    logic [15:0] off_exp;

    // write channel: address and data taken in either order
    assign wr_do = !s_axi_awready_out && !s_axi_wready_out &&
                   !s_axi_bvalid_out;
    assign wr_idx = aw_addr[9:2];
    assign wr_ok = (aw_addr[11:10] == 2'h0) &&
                   (wr_idx == `IRATP_IDX_OFFSET || wr_idx == `IRATP_IDX_LED ||
                    wr_idx == `IRATP_IDX_REC || wr_idx == `IRATP_IDX_GAIN ||
                    wr_idx == `IRATP_IDX_CTRL || wr_idx == `IRATP_IDX_STAT ||
                    wr_idx == `IRATP_IDX_RESULT);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s_axi_awready_out <= 1'b1;
            aw_addr <= 12'h000;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            s_axi_awready_out <= 1'b0;
            aw_addr <= s_axi_awaddr_in;
        end else if (wr_do) begin
            s_axi_awready_out <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s_axi_wready_out <= 1'b1;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            s_axi_wready_out <= 1'b0;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
        end else if (wr_do) begin
            s_axi_wready_out <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `IRATP_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_ok ? `IRATP_RESP_OKAY : `IRATP_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // parameter registers, reserved bits dropped on write
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            measurement_offset <= `IRATP_RST_OFFSET;
            led_recovery_field <= `IRATP_RST_LED;
            infrared_recovery_code <=
                3'(`IRATP_RST_REC >> `IRATP_REC_LSB);
            infrared_integration_gain <= 3'(`IRATP_RST_GAIN);
        end else if (wr_do && w_strb[0]) begin
            if (wr_idx == `IRATP_IDX_OFFSET)
                measurement_offset <= w_data[7:0];
            if (wr_idx == `IRATP_IDX_LED)
                led_recovery_field <= w_data[7:0];
            if (wr_idx == `IRATP_IDX_REC)
                infrared_recovery_code <=
                    w_data[`IRATP_REC_MSB:`IRATP_REC_LSB];
            if (wr_idx == `IRATP_IDX_GAIN)
                infrared_integration_gain <= w_data[`IRATP_GAIN_MSB:0];
        end
    end

    // start request and done flag; a set beats a clear
    assign done_clear = wr_do && w_strb[0] && wr_idx == `IRATP_IDX_STAT &&
                        w_data[`IRATP_STAT_DONE];

    always_ff @(posedge clock_in) begin
        if (!rst_n_in)
            sw_start <= 1'b0;
        else if (wr_do && w_strb[0] && wr_idx == `IRATP_IDX_CTRL)
            sw_start <= w_data[`IRATP_CTRL_START];
        else if (start_go)
            sw_start <= 1'b0;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in)
            done_flag <= 1'b0;
        else if (state == st_report)
            done_flag <= 1'b1;
        else if (done_clear)
            done_flag <= 1'b0;
    end

    // read channel
    assign rd_idx = s_axi_araddr_in[9:2];

    always_comb begin
        rd_word = 32'h00000000;
        rd_ok = s_axi_araddr_in[11:10] == 2'h0;
        unique case (rd_idx)
            `IRATP_IDX_OFFSET: rd_word[7:0] = measurement_offset;
            `IRATP_IDX_LED: rd_word[7:0] = led_recovery_field;
            `IRATP_IDX_REC:
                rd_word[`IRATP_REC_MSB:`IRATP_REC_LSB] = infrared_recovery_code;
            `IRATP_IDX_GAIN:
                rd_word[`IRATP_GAIN_MSB:0] = infrared_integration_gain;
            `IRATP_IDX_CTRL: rd_word[`IRATP_CTRL_START] = sw_start;
            `IRATP_IDX_STAT: begin
                rd_word[`IRATP_STAT_BUSY] = busy_out;
                rd_word[`IRATP_STAT_DONE] = done_flag;
                rd_word[`IRATP_STAT_OVR] = result_out.overrange;
            end
            `IRATP_IDX_RESULT: rd_word[15:0] = result_out.value;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `IRATP_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_ok ? rd_word : 32'h00000000;
            s_axi_rresp_out <= rd_ok ? `IRATP_RESP_OKAY : `IRATP_RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // measurement sequencer
    assign start_go = (state == st_idle) && (start_in || sw_start);
    assign tick_now = (state == st_integ) && (div_cnt == div_top(snap.gain));
    assign ovr_any = ovr_seen || overrange_in;
    assign off_exp = expand_offset(snap.offset);

    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: if (start_go) next_state = st_recover;
            st_recover: if (rec_left == 16'h0001) next_state = st_integ;
            st_integ: begin
                if (tick_now && integ_left == 8'h01) next_state = st_report;
            end
            st_report: next_state = st_idle;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in)
            state <= st_idle;
        else
            state <= next_state;
    end

    // settings are frozen for the whole measurement
    always_ff @(posedge clock_in) begin
        if (!rst_n_in)
            snap <= '0;
        else if (start_go)
            snap <= '{measurement_offset, infrared_recovery_code,
                      infrared_integration_gain};
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in)
            rec_left <= 16'h0000;
        else if (start_go)
            rec_left <= rec_cycles(infrared_recovery_code,
                                   infrared_integration_gain);
        else if (state == st_recover)
            rec_left <= rec_left - 16'h0001;
    end

    // converter clock divided by 2^gain during integration
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            div_cnt <= 8'h00;
            integ_left <= 8'h00;
        end else if (state != st_integ) begin
            div_cnt <= 8'h00;
            integ_left <= `IRATP_INTEG_TICKS;
        end else if (tick_now) begin
            div_cnt <= 8'h00;
            integ_left <= integ_left - 8'h01;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in)
            ovr_seen <= 1'b0;
        else if (start_go)
            ovr_seen <= 1'b0;
        else if (state == st_integ && overrange_in)
            ovr_seen <= 1'b1;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            result_out <= '0;
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= state == st_report;
            if (state == st_report) begin
                result_out.overrange <= ovr_any;
                result_out.value <= ovr_any ? `IRATP_OVERRANGE :
                    report_value(sample_in, off_exp);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
            recovering_out <= 1'b0;
            integrating_out <= 1'b0;
            adc_tick_out <= 1'b0;
        end else begin
            busy_out <= next_state != st_idle;
            recovering_out <= next_state == st_recover;
            integrating_out <= next_state == st_integ;
            adc_tick_out <= tick_now;
        end
    end

    // checking aids: cycles spent in the current state
    logic [15:0] phase_len;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || next_state != state)
            phase_len <= 16'h0000;
        else
            phase_len <= phase_len + 16'h0001;
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_launch;
        start_go;
    endsequence
    sequence s_recover_begun;
        state == st_recover ##0 recovering_out;
    endsequence

    a_offset_added: assert property (
        state == st_report && !ovr_any && !sample_in[16] &&
        ({1'b0, sample_in[15:0]} + {1'b0, off_exp} < 17'h0FFFF)
        |=> result_out.value == $past(sample_in[15:0] + off_exp))
        else $error("offset not added to result");
    a_overrange_code: assert property (
        result_valid_out |->
        ((result_out.value == `IRATP_OVERRANGE) == result_out.overrange))
        else $error("overrange code misused");
    a_offset_decode: assert property (
        expand_offset(8'h60) == 16'h0040 &&
        expand_offset(8'h70) == 16'h0080 &&
        expand_offset(8'h80) == 16'h0100)
        else $error("offset decode wrong");
    a_recovery_first: assert property (
        s_launch |=> s_recover_begun)
        else $error("measurement did not begin with recovery");
    a_recovery_length: assert property (
        state == st_recover && next_state == st_integ |->
        phase_len == rec_cycles(snap.rec, snap.gain) - 16'h0001)
        else $error("recovery length wrong");
    a_integ_length: assert property (
        state == st_integ && next_state == st_report |->
        phase_len == ({8'h00, `IRATP_INTEG_TICKS} << snap.gain) - 16'h0001)
        else $error("integration length wrong");
    a_gain_max: assert property (
        state == st_integ && next_state == st_report && snap.gain == 3'h7
        |-> phase_len == {8'h00, `IRATP_INTEG_TICKS} * 16'h0080 - 16'h0001)
        else $error("largest gain not 128");
    a_divide_sixteen: assert property (
        tick_now && snap.gain == 3'h4 && integ_left > 8'h01
        |=> div_cnt == 8'h00 ##15 tick_now)
        else $error("gain 4 does not divide by 16");
    a_divide_one: assert property (
        state == st_integ && snap.gain == 3'h0 |-> tick_now)
        else $error("gain 0 does not divide by 1");
    a_settings_held: assert property (
        state != st_idle && $past(state) != st_idle |-> $stable(snap))
        else $error("settings changed mid measurement");
endmodule // iratp_top

// [test/ir_adc_timing_offset_params_tb_top.sv]
// bench for the converter offset, recovery and gain parameter block
// assumes: uut at 10 MHz, axi4-lite register access, start by pin or register
`timescale 1ns/10ps
`include "iratp_map.svh"
module ir_adc_timing_offset_params_tb_top;
    import iratp_pkg::*;
    logic clock_in = 1'b0, rst_n_in = 1'b0;
    logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
    logic [31:0] w_data = 32'h00000000;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
    logic ar_valid = 1'b0, r_ready = 1'b0;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0] b_resp, r_resp, resp;
    logic [31:0] r_data, rd_val;
    logic start = 1'b0, ovr_in = 1'b0;
    logic [16:0] sample = 17'h00000;
    logic busy, recovering, integrating, tick, res_valid;
    iratp_res_s result;
    int err_total = 0, n_checks = 0, cycles = 0;
    int rc = 0, ic = 0, tc = 0, bc = 0, cap_r, cap_i, cap_t, cap_b;
    logic [2:0] gains [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
    iratp_top uut (
        .clock_in(clock_in), .rst_n_in(rst_n_in),
        .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid),
        .s_axi_awready_out(aw_ready), .s_axi_wdata_in(w_data),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_valid),
        .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp),
        .s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready),
        .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
        .s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data),
        .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid),
        .s_axi_rready_in(r_ready), .start_in(start), .sample_in(sample),
        .overrange_in(ovr_in), .busy_out(busy), .recovering_out(recovering),
        .integrating_out(integrating), .adc_tick_out(tick),
        .result_valid_out(res_valid), .result_out(result)
    );
    initial begin
        forever #50 clock_in = ~clock_in;
    end
    // cycle counts of each measurement, latched at its result pulse
    always @(posedge clock_in) begin
        cycles = cycles + 1;
        if (cycles > 20000) begin
            err_total = err_total + 1;
            test_done();
        end else if (res_valid === 1'b1) begin
            cap_r = rc; cap_i = ic; cap_t = tc; cap_b = bc;
            rc = 0; ic = 0; tc = 0; bc = 0;
        end else begin
            rc = rc + ((recovering === 1'b1) ? 1 : 0);
            ic = ic + ((integrating === 1'b1) ? 1 : 0);
            tc = tc + ((tick === 1'b1) ? 1 : 0);
            bc = bc + ((busy === 1'b1) ? 1 : 0);
        end
    end
    task automatic test_done();
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        aw_addr <= {2'b00, idx, 2'b00};
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock_in);
            if (!aw_ok && aw_ready === 1'b1) begin
                aw_ok = 1'b1;
                aw_valid <= 1'b0;
            end
            if (!w_ok && w_ready === 1'b1) begin
                w_ok = 1'b1;
                w_valid <= 1'b0;
            end
        end
        do @(posedge clock_in); while (b_valid !== 1'b1);
        resp = b_resp;
    endtask
    task automatic rd(input logic [7:0] idx);
        ar_addr <= {2'b00, idx, 2'b00};
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do @(posedge clock_in); while (ar_ready !== 1'b1);
        ar_valid <= 1'b0;
        do @(posedge clock_in); while (r_valid !== 1'b1);
        rd_val = r_data;
        resp = r_resp;
    endtask
    task automatic go(input logic [16:0] s, input logic o);
        sample <= s;
        ovr_in <= o;
        start <= 1'b1;
        @(posedge clock_in);
        start <= 1'b0;
    endtask
    task automatic finish_meas(input logic [15:0] val, input logic o);
        do @(posedge clock_in); while (res_valid !== 1'b1);
        @(posedge clock_in);
        chk("result value", {16'h0000, result.value}, {16'h0000, val});
        chk("result overrange", {31'h0, result.overrange}, {31'h0, o});
    endtask
    task automatic timing(input logic [2:0] r, input logic [2:0] g);
        int n, rx, ix;
        n = (r == 3'h0) ? 1 : (1 << (r + 2)) - 1;
        rx = (n * 50 * (1 << g) + 99) / 100;
        ix = 4 * (1 << g);
        chk("recovery cycles", cap_r, rx);
        chk("integration cycles", cap_i, ix);
        chk("divided ticks", cap_t, 4);
        chk("busy cycles", cap_b, rx + ix + 1);
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        rd(`IRATP_IDX_OFFSET);
        chk("offset reset", rd_val, 32'h00000060);
        rd(`IRATP_IDX_LED);
        chk("led reset", rd_val, 32'h00000000);
        rd(`IRATP_IDX_REC);
        chk("recovery reset", rd_val, 32'h00000070);
        rd(`IRATP_IDX_GAIN);
        chk("gain reset", rd_val, 32'h00000000);
        wr(`IRATP_IDX_REC, 32'h000000FF);
        rd(`IRATP_IDX_REC);
        chk("recovery field", rd_val, 32'h00000070);
        wr(`IRATP_IDX_GAIN, 32'h000000FF);
        chk("write resp", {30'h0, resp}, {30'h0, `IRATP_RESP_OKAY});
        rd(`IRATP_IDX_GAIN);
        chk("gain field", rd_val, 32'h00000007);
        rd(8'h30);
        chk("unmapped resp", {30'h0, resp}, {30'h0, `IRATP_RESP_SLVERR});
        chk("unmapped data", rd_val, 32'h00000000);
        wr(8'h30, 32'h00000000);
        chk("unmapped wresp", {30'h0, resp}, {30'h0, `IRATP_RESP_SLVERR});
        // recovery set to the complement of each gain
        foreach (gains[k]) begin
            wr(`IRATP_IDX_GAIN, {29'h0, gains[k]});
            wr(`IRATP_IDX_REC, {25'h0, ~gains[k], 4'h0});
            go(17'h00000, 1'b0);
            finish_meas(16'h0040, 1'b0);
            timing(~gains[k], gains[k]);
        end
        wr(`IRATP_IDX_GAIN, 32'h00000000);
        wr(`IRATP_IDX_REC, 32'h00000000);
        wr(`IRATP_IDX_OFFSET, 32'h00000070);
        go(17'h00005, 1'b0);
        finish_meas(16'h0085, 1'b0);
        timing(3'h0, 3'h0);
        wr(`IRATP_IDX_OFFSET, 32'h00000080);
        go(17'h1FFF6, 1'b0);
        finish_meas(16'h00F6, 1'b0);
        go(17'h0FFFF, 1'b0);
        finish_meas(`IRATP_RESULT_MAX, 1'b0);
        go(17'h00010, 1'b1);
        finish_meas(`IRATP_OVERRANGE, 1'b1);
        // settings changed during recovery wait for the next start
        wr(`IRATP_IDX_REC, 32'h00000070);
        go(17'h00000, 1'b0);
        wr(`IRATP_IDX_GAIN, 32'h00000003);
        wr(`IRATP_IDX_OFFSET, 32'h00000060);
        rd(`IRATP_IDX_STAT);
        chk("status busy", rd_val, 32'h00000007);
        finish_meas(16'h0100, 1'b0);
        timing(3'h7, 3'h0);
        wr(`IRATP_IDX_REC, 32'h00000040);
        wr(`IRATP_IDX_CTRL, 32'h00000001);
        finish_meas(16'h0040, 1'b0);
        timing(3'h4, 3'h3);
        rd(`IRATP_IDX_STAT);
        chk("status done", rd_val, 32'h00000002);
        rd(`IRATP_IDX_RESULT);
        chk("result register", rd_val, 32'h00000040);
        wr(`IRATP_IDX_STAT, 32'h00000002);
        rd(`IRATP_IDX_STAT);
        chk("status cleared", rd_val, 32'h00000000);
        test_done();
    end
endmodule // ir_adc_timing_offset_params_tb_top
